// ---- core/rrdm_ctrl.v ----
// Receiver rate range and demodulation mode control with APB access
//
// Summary of operation
// - Two rate select bits pick range 0..3, high bit most significant.
// - Range change in active mode completes within 100 us, same modulation.
// - Range plus modulation change waits full start-up of the new range.
// - Without signal at start-up, output follows noise after start-up.
// - Any data format passes through; long edge-free gaps are tolerated.
// - Mode select high chooses ASK, low chooses FSK.
// - Mode change time is start-up time of the newly selected range.
// - Demodulated output forced low throughout signal start-up.
// - Enable and receive-on give off, standby or active mode.
// - Active entry waits PLL start-up, then range-dependent signal start-up.
// - Output high for upper FSK tone or ASK carrier, low otherwise.
// - Sample timing from clock divided by 16, times 8/4/2/1 per range; start-up timers count microseconds.
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "rrdm_regs.vh"

////////////////////////////////////////////////////////////////////////////
// Sample FIFO
module rrdm_fifo #(
  parameter W = 8,
  parameter D = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire clk_sys,
  input wire srst,
  // Fill side
  input wire s_valid,
  output wire s_ready,
  input wire [W-1:0] s_data,
  // Drain side
  output wire m_valid,
  input wire m_ready,
  output wire [W-1:0] m_data
);
  reg [W-1:0] mem_q [0:D-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  assign s_ready = (cnt_q != D);
  assign m_valid = (cnt_q != {(AW+1){1'b0}});
  assign m_data = mem_q[rd_q];
  assign push = s_valid & s_ready;
  assign pop = m_valid & m_ready;
  always @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_q] <= s_data;
    end
  end
  always @(posedge clk_sys) begin
    if (srst) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
// Top level control block
module rrdm_ctrl #(
  parameter [7:0] TICKS_PER_US = `RRDM_CLK_MHZ
) (
  // Clock and reset
  input wire clk_sys,
  input wire srst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Demodulator side
  input wire demod_in,
  output reg data_out,
  output reg osc_on,
  output reg rx_path_on
);
  localparam [2:0] ST_OFF = 3'h0;
  localparam [2:0] ST_STBY = 3'h1;
  localparam [2:0] ST_PLL = 3'h2;
  localparam [2:0] ST_SIG = 3'h3;
  localparam [2:0] ST_ACT = 3'h4;
  localparam [2:0] ST_RSW = 3'h5;

  // Address decode
  function hit;
    input [11:0] a;
    input [11:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // Signal start-up time per range in us
  function [10:0] sig_us;
    input [1:0] r;
    begin
      case (r)
        2'h0: sig_us = `RRDM_T_SIG0_US;
        2'h1: sig_us = `RRDM_T_SIG1_US;
        2'h2: sig_us = `RRDM_T_SIG2_US;
        default: sig_us = `RRDM_T_SIG3_US;
      endcase
    end
  endfunction

  reg [4:0] ctrl_q;
  reg [2:0] st_q;
  reg [1:0] app_rate_q;
  reg app_mod_q;
  reg [7:0] us_pre_q;
  reg [10:0] tmr_q;
  reg [3:0] dtick_q;
  reg [2:0] rtick_q;
  reg filt_q;
  reg smp_q;
  reg [7:0] shf_q;
  reg [2:0] nbit_q;
  reg push_q;
  reg ovf_q;
  wire fifo_ready;
  wire fifo_valid;
  wire [7:0] fifo_data;
  wire acc;
  wire done;
  wire rd_data;
  wire us_stb;
  wire dtick;
  wire rtick;
  wire live;
  wire [1:0] cfg_rate;
  wire cfg_mod;
  wire [2:0] rmask;

  assign acc = psel & penable & pready;
  assign rd_data = acc & ~pwrite & hit(paddr, `RRDM_OFS_DATA);
  assign cfg_rate = {ctrl_q[`RRDM_CTRL_RATE_HI],
                     ctrl_q[`RRDM_CTRL_RATE_LO]};
  assign cfg_mod = ctrl_q[`RRDM_CTRL_MOD];
  assign us_stb = (us_pre_q == TICKS_PER_US - 8'h01);
  assign done = (tmr_q == 11'h000);
  assign live = (st_q == ST_ACT) | (st_q == ST_RSW);

  ////////////////////////////////////////////////////////////////////////////
  // APB registers
  always @(posedge clk_sys) begin
    if (srst) begin
      ctrl_q <= `RRDM_CTRL_RST;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        pslverr <= ~(hit(paddr, `RRDM_OFS_CTRL) |
                     hit(paddr, `RRDM_OFS_STATUS) |
                     hit(paddr, `RRDM_OFS_DATA));
        prdata <= 32'h0000_0000;
        if (hit(paddr, `RRDM_OFS_CTRL)) begin
          prdata <= {27'h0, ctrl_q};
        end else if (hit(paddr, `RRDM_OFS_STATUS)) begin
          prdata <= {23'h0, ovf_q, ~fifo_ready, app_mod_q, app_rate_q,
                     (st_q == ST_PLL) | (st_q == ST_SIG), st_q};
        end else if (hit(paddr, `RRDM_OFS_DATA)) begin
          prdata <= {23'h0, fifo_valid, fifo_data};
        end
      end else begin
        pslverr <= 1'b0;
      end
      if (acc & pwrite & hit(paddr, `RRDM_OFS_CTRL)) begin
        ctrl_q <= pwdata[4:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time bases
  assign dtick = (dtick_q == 4'hF);
  assign rmask = (app_rate_q == 2'h0) ? 3'h7 :
                 (app_rate_q == 2'h1) ? 3'h3 :
                 (app_rate_q == 2'h2) ? 3'h1 : 3'h0;
  assign rtick = dtick & ((rtick_q & rmask) == 3'h0);
  always @(posedge clk_sys) begin
    if (srst | (st_q == ST_OFF)) begin
      us_pre_q <= 8'h00;
      dtick_q <= 4'h0;
      rtick_q <= 3'h0;
    end else begin
      us_pre_q <= us_stb ? 8'h00 : us_pre_q + 8'h01;
      dtick_q <= dtick_q + 4'h1;
      if (dtick) begin
        rtick_q <= rtick_q + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power mode and start-up sequencing
  always @(posedge clk_sys) begin
    if (srst) begin
      st_q <= ST_OFF;
      tmr_q <= 11'h000;
      app_rate_q <= 2'h0;
      app_mod_q <= 1'b1;
    end else begin
      if (us_stb & ~done) begin
        tmr_q <= tmr_q - 11'h001;
      end
      case (st_q)
        ST_OFF, ST_STBY: begin
          app_rate_q <= cfg_rate;
          app_mod_q <= cfg_mod;
          if (ctrl_q[`RRDM_CTRL_ENABLE] & ctrl_q[`RRDM_CTRL_RX_ON]) begin
            st_q <= ST_PLL;
            tmr_q <= `RRDM_T_PLL_US;
          end else if (ctrl_q[`RRDM_CTRL_ENABLE]) begin
            st_q <= ST_STBY;
          end else begin
            st_q <= ST_OFF;
          end
        end
        ST_PLL, ST_SIG, ST_ACT, ST_RSW: begin
          if (~(ctrl_q[`RRDM_CTRL_ENABLE] & ctrl_q[`RRDM_CTRL_RX_ON])) begin
            st_q <= ctrl_q[`RRDM_CTRL_ENABLE] ? ST_STBY : ST_OFF;
          end else if (st_q == ST_PLL) begin
            app_rate_q <= cfg_rate;
            app_mod_q <= cfg_mod;
            if (done) begin
              st_q <= ST_SIG;
              tmr_q <= sig_us(cfg_rate);
            end
          end else if ((cfg_mod != app_mod_q) |
                       ((st_q == ST_SIG) & (cfg_rate != app_rate_q))) begin
            app_rate_q <= cfg_rate;
            app_mod_q <= cfg_mod;
            st_q <= ST_SIG;
            tmr_q <= sig_us(cfg_rate);
          end else if (cfg_rate != app_rate_q) begin
            app_rate_q <= cfg_rate;
            st_q <= ST_RSW;
            tmr_q <= `RRDM_T_SWITCH_US;
          end else if (done) begin
            st_q <= ST_ACT;
          end
        end
        default: begin
          st_q <= ST_OFF;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Debounce, output and sample packing
  always @(posedge clk_sys) begin
    if (srst) begin
      filt_q <= 1'b0;
      smp_q <= 1'b0;
      data_out <= 1'b0;
      osc_on <= 1'b0;
      rx_path_on <= 1'b0;
      shf_q <= 8'h00;
      nbit_q <= 3'h0;
      push_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      osc_on <= (st_q != ST_OFF);
      rx_path_on <= (st_q != ST_OFF) & (st_q != ST_STBY);
      if (rtick) begin
        smp_q <= demod_in;
        if (smp_q == demod_in) begin
          filt_q <= demod_in;
        end
      end
      data_out <= live & filt_q;
      if (push_q & fifo_ready) begin
        push_q <= 1'b0;
      end
      if (rtick & live & ~(push_q & ~fifo_ready)) begin
        shf_q <= {shf_q[6:0], filt_q};
        nbit_q <= nbit_q + 3'h1;
        if (nbit_q == 3'h7) begin
          push_q <= 1'b1;
        end
      end
      if (rtick & live & push_q & ~fifo_ready) begin
        ovf_q <= 1'b1;
      end else if (acc & pwrite & hit(paddr, `RRDM_OFS_STATUS) &
                   pwdata[`RRDM_ST_OVF]) begin
        ovf_q <= 1'b0;
      end
    end
  end

  rrdm_fifo #(
    .W(`RRDM_WORD_W),
    .D(`RRDM_FIFO_DEPTH),
    .AW(`RRDM_FIFO_AW)
  ) u_fifo (
    .clk_sys(clk_sys),
    .srst(srst),
    .s_valid(push_q),
    .s_ready(fifo_ready),
    .s_data(shf_q),
    .m_valid(fifo_valid),
    .m_ready(rd_data),
    .m_data(fifo_data)
  );
endmodule

// ---- core/rrdm_regs.vh ----
// Register map, reset values and timing constants of the rate/mode control
`ifndef RRDM_REGS_VH
`define RRDM_REGS_VH
`define RRDM_OFS_CTRL 12'h000
`define RRDM_OFS_STATUS 12'h004
`define RRDM_OFS_DATA 12'h008
`define RRDM_CTRL_ENABLE 0
`define RRDM_CTRL_RX_ON 1
`define RRDM_CTRL_RATE_LO 2
`define RRDM_CTRL_RATE_HI 3
`define RRDM_CTRL_MOD 4
`define RRDM_CTRL_RST 5'h10
`define RRDM_ST_OVF 8
`define RRDM_DATA_VALID 8
`define RRDM_CLK_MHZ 8'h32
`define RRDM_DTICK_DIV 16
`define RRDM_T_SWITCH_US 11'h064
`define RRDM_T_PLL_US 11'h105
`define RRDM_T_SIG0_US 11'h448
`define RRDM_T_SIG1_US 11'h284
`define RRDM_T_SIG2_US 11'h1A1
`define RRDM_T_SIG3_US 11'h130
`define RRDM_FIFO_DEPTH 16
`define RRDM_FIFO_AW 4
`define RRDM_WORD_W 8
`endif

// ---- test/rrdm_asserts.sv ----
// Port checker of the rate and mode control
`timescale 1ns/10ps
module rrdm_asserts #(
  parameter [7:0] TICKS_PER_US = 8'h32
) (
  // Clock and reset
  input wire clk_sys,
  input wire srst,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Demodulator side
  input wire demod_in,
  input wire data_out,
  input wire osc_on,
  input wire rx_path_on
);
  localparam int SU_MIN = 563 * TICKS_PER_US;
  logic [15:0] su_q;
  // Cycles since the receive path came on
  always @(posedge clk_sys) begin
    if (srst || !rx_path_on) su_q <= 16'h0000;
    else if (su_q != 16'hFFFF) su_q <= su_q + 16'h0001;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable;
  endsequence
  a_ready_wait: assert property (setup_s ##1 access_s |=> pready)
    else $error("pready missing after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_idle: assert property (!psel |=> !pready)
    else $error("pready without transfer");
  a_err_map: assert property (pready |->
    pslverr == !(paddr inside {12'h000, 12'h004, 12'h008}))
    else $error("pslverr wrong for address");
  a_err_zero: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("read data not zero on error");
  a_reset_quiet: assert property ($fell(srst) |->
    !osc_on && !rx_path_on && !data_out)
    else $error("outputs not low after reset");
  a_rx_osc: assert property (rx_path_on |-> osc_on)
    else $error("receive path on without oscillator");
  a_data_gated: assert property (!rx_path_on |-> !data_out)
    else $error("data out high with path off");
  a_startup_low: assert property (rx_path_on && su_q < SU_MIN |->
    !data_out)
    else $error("data out high during start-up");
endmodule
bind rrdm_ctrl rrdm_asserts #(.TICKS_PER_US(TICKS_PER_US)) rrdm_asserts_i (
  .clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .demod_in(demod_in),
  .data_out(data_out), .osc_on(osc_on), .rx_path_on(rx_path_on));

// ---- test/rrdm_src.sv ----
// Demodulated data source in place of the analog path
`timescale 1ns/10ps
module rrdm_src (
  // Clock
  input wire clk_sys,
  // One less than the cycles between edges, zero holds the carrier
  input wire [7:0] half,
  // Demodulated data
  output logic demod_in = 1'b1
);
  logic [7:0] cnt_q = 8'h00;
  always @(posedge clk_sys) begin
    cnt_q <= (cnt_q >= half) ? 8'h00 : cnt_q + 8'h01;
    if (half == 8'h00) demod_in <= 1'b1;
    else if (cnt_q >= half) demod_in <= ~demod_in;
  end
endmodule

// ---- test/rrdm_ctrl_bench.sv ----
// Self-checking bench of the rate and mode control
`timescale 1ns/10ps
module rrdm_ctrl_bench;
  typedef struct packed {
    logic w;
    logic [11:0] a;
    logic [31:0] d, x, m;
    logic e;
  } rrdm_row_t;
  logic clk_sys = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, er, lv;
  logic demod_in, data_out, osc_on, rx_path_on;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] half = 8'h00;
  int n_fail = 0, check_count = 0, cyc = 0, n, k;
  int su[4] = '{1096, 644, 417, 304};
  rrdm_row_t rows[8] = '{
    '{1'b0, 12'h000, 32'h0, 32'h10, 32'hFFFFFFFF, 1'b0},
    '{1'b1, 12'h000, 32'h1, 32'h0, 32'h0, 1'b0},
    '{1'b0, 12'h000, 32'h0, 32'h1, 32'hFFFFFFFF, 1'b0},
    '{1'b0, 12'h004, 32'h0, 32'h1, 32'h7, 1'b0},
    '{1'b0, 12'h00C, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b1},
    '{1'b1, 12'hFFC, 32'hFF, 32'h0, 32'h0, 1'b1},
    '{1'b0, 12'h000, 32'h0, 32'h1, 32'hFFFFFFFF, 1'b0},
    '{1'b0, 12'h008, 32'h0, 32'h0, 32'h100, 1'b0}};
  always #10 clk_sys = ~clk_sys;
  rrdm_ctrl #(.TICKS_PER_US(8'h01)) rrdm_ctrl_i (
    .clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .demod_in(demod_in),
    .data_out(data_out), .osc_on(osc_on), .rx_path_on(rx_path_on));
  rrdm_src rrdm_src_i (.clk_sys(clk_sys), .half(half),
    .demod_in(demod_in));
  //////////////////////////////////////
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", s, x, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task wait_hi;
    n = 0;
    while (data_out !== 1'b1 && n < 4000) begin
      @(posedge clk_sys);
      n++;
    end
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict;
    end
  end
  //////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk("rdata", rows[i].x, rd & rows[i].m);
      chk("pslverr", {31'h0, rows[i].e}, {31'h0, er});
    end
    foreach (su[r]) begin
      apb(1'b1, 12'h000, 32'h0);
      repeat (3) @(posedge clk_sys);
      chk("osc_on", 32'h0, {31'h0, osc_on});
      apb(1'b1, 12'h000, 32'h13 | (r << 2));
      wait_hi;
      chk("startup", 32'h1, n > su[r] + 255 && n < su[r] + 270);
    end
    apb(1'b1, 12'h000, 32'h17);
    repeat (60) @(posedge clk_sys);
    chk("data_out", 32'h1, {31'h0, data_out});
    repeat (60) @(posedge clk_sys);
    apb(1'b0, 12'h004, 32'h0);
    chk("status", 32'h14, rd & 32'h37);
    apb(1'b1, 12'h000, 32'h0B);
    repeat (3) @(posedge clk_sys);
    chk("gate", 32'h0, {31'h0, data_out});
    wait_hi;
    chk("switch", 32'h1, n > 405 && n < 428);
    half <= 8'h64;
    k = 0;
    lv = data_out;
    repeat (600) begin
      @(posedge clk_sys);
      k += (data_out !== lv);
      lv = data_out;
    end
    chk("toggle", 32'h1, k > 3);
    half <= 8'h00;
    apb(1'b1, 12'h000, 32'h1F);
    repeat (2600) @(posedge clk_sys);
    apb(1'b0, 12'h004, 32'h0);
    chk("fifo", 32'h180, rd & 32'h180);
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b1, 12'h004, 32'h100);
    apb(1'b0, 12'h004, 32'h0);
    chk("ovf_clr", 32'h80, rd & 32'h180);
    // Sixteen stored words plus the one held back while full
    repeat (17) begin
      apb(1'b0, 12'h008, 32'h0);
      chk("pop", 32'h100, rd & 32'h100);
    end
    apb(1'b0, 12'h008, 32'h0);
    chk("empty", 32'h0, rd & 32'h100);
    srst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    chk("osc_rst", 32'h0, {31'h0, osc_on});
    apb(1'b0, 12'h004, 32'h0);
    chk("st_rst", 32'h40, rd);
    print_verdict;
  end
endmodule
